// ==== include/tksu_defines.vh ====
// register map, field layout, reset values and counts of the touch unit
`ifndef TKSU_DEFINES_VH
`define TKSU_DEFINES_VH

// register byte offsets
`define TKSU_OFF_CTRL        8'h00
`define TKSU_OFF_SEQ         8'h04
`define TKSU_OFF_STATUS      8'h08
`define TKSU_OFF_MASK        8'h0C
`define TKSU_OFF_CHARGE2     8'h10
`define TKSU_OFF_CHGOFFSET   8'h3C
`define TKSU_OFF_START_DATA  8'h4C

// control register fields
`define TKSU_CTRL_POWER_BIT  0
`define TKSU_CTRL_TOUCH_BIT  1
`define TKSU_CTRL_W          2

// sequence register: channel of the first regular slot
`define TKSU_SEQ_CH_W        5

// status and mask fields
`define TKSU_ST_EOC_BIT      0
`define TKSU_ST_DROP_BIT     1
`define TKSU_ST_W            2
`define TKSU_ST_BUSY_BIT     8

// charge selector layout
`define TKSU_SEL_W           3
`define TKSU_SEL_NUM         10
`define TKSU_CHARGE2_W       30

// byte-wide fields and the 16-bit data field
`define TKSU_OFFSET_W        8
`define TKSU_DCG_W           8
`define TKSU_DATA_W          16

// reset values
`define TKSU_RST_CTRL        2'h0
`define TKSU_RST_SEQ         5'h00
`define TKSU_RST_MASK        2'h0
`define TKSU_RST_CHARGE2     30'h00000000
`define TKSU_RST_OFFSET      8'h00
`define TKSU_RST_DCG         8'h00
`define TKSU_RST_DATA        16'h0000

// charge selector decode: base cycles of the even and odd families
`define TKSU_CHG_BASE_LOW    9'h004
`define TKSU_CHG_BASE_HIGH   9'h005

// width of the phase timer
`define TKSU_CNT_W           9

`endif

// ==== verilog/tksu_phase_timer.v ====
// loadable down counter that times one phase of a touch measurement
`timescale 1ns/1ps
module tksu_phase_timer #(
  parameter CNT_W = 9
) (
  // clock and reset
  input  wire             pclk,
  input  wire             presetn,
  // control
  input  wire             load,
  input  wire [CNT_W-1:0] load_value,
  input  wire             tick,
  // status
  output reg              done_ff
);

  reg [CNT_W-1:0] cnt_ff;
  reg             run_ff;

  // a loaded count of n ends after n ticks; a count of zero ends at once
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_ff  <= {CNT_W{1'b0}};
      run_ff  <= 1'b0;
      done_ff <= 1'b0;
    end
    else if (load)
    begin
      cnt_ff  <= load_value;
      run_ff  <= 1'b1;
      done_ff <= 1'b0;
    end
    else if (run_ff && cnt_ff == {CNT_W{1'b0}})
    begin
      run_ff  <= 1'b0;
      done_ff <= 1'b1;
    end
    else
    begin
      done_ff <= 1'b0;
      if (run_ff && tick)
        cnt_ff <= cnt_ff - {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

endmodule // tksu_phase_timer

// ==== verilog/tksu_charge_ctrl.v ====
// touch-sense charge control: apb registers and measurement sequencer
`timescale 1ns/1ps
`include "tksu_defines.vh"
module tksu_charge_ctrl #(
  parameter ADC_DIV = 2
) (
  // clock and reset
  input  wire                           pclk,
  input  wire                           presetn,
  // apb slave
  input  wire                           psel,
  input  wire                           penable,
  input  wire                           pwrite,
  input  wire [7:0]                     paddr,
  input  wire [31:0]                    pwdata,
  output reg  [31:0]                    prdata_ff,
  output reg                            pready_ff,
  output reg                            pslverr_ff,
  // adc conversion unit
  input  wire                           adc_conv_done,
  input  wire [`TKSU_DATA_W-1:0]        adc_conv_data,
  input  wire [`TKSU_DATA_W-1:0]        adc_injected_result_first,
  output reg                            adc_power_on_ff,
  output reg                            touch_enable_ff,
  output reg  [`TKSU_SEQ_CH_W-1:0]      adc_channel_ff,
  output reg  [`TKSU_CHARGE2_W-1:0]     adc_sample_time_second_ff,
  output reg                            adc_conv_start_ff,
  // electrode drive
  output reg                            discharge_en_ff,
  output reg                            charge_en_ff,
  // interrupt
  output reg                            irq_ff
);

  // one-hot sequencer states
  localparam [4:0] ST_IDLE   = 5'h01;
  localparam [4:0] ST_DISCH  = 5'h02;
  localparam [4:0] ST_CHGSEL = 5'h04;
  localparam [4:0] ST_CHGOFF = 5'h08;
  localparam [4:0] ST_CONV   = 5'h10;

  localparam CW = `TKSU_CNT_W;

  // selector code to ADC clock cycles
  function [CW-1:0] tksu_chg_cycles;
    input [`TKSU_SEL_W-1:0] code;
    begin
      if (code[2])
        tksu_chg_cycles = `TKSU_CHG_BASE_HIGH + {6'h00, code[1:0], 1'b0};
      else
        tksu_chg_cycles = `TKSU_CHG_BASE_LOW + {6'h00, code[1:0], 1'b0};
    end
  endfunction

  // registers
  reg [`TKSU_OFFSET_W-1:0]  chg_offset_ff;
  reg [`TKSU_DCG_W-1:0]     dcg_time_ff;
  reg [`TKSU_DATA_W-1:0]    result_ff;
  reg [`TKSU_ST_W-1:0]      status_ff;
  reg [`TKSU_ST_W-1:0]      mask_ff;
  reg [4:0]                 state_ff;
  reg [4:0]                 nxt_state;
  reg [CW-1:0]              div_ff;
  reg                       adc_tick_ff;
  reg [31:0]                nxt_rdata;
  reg                       nxt_err;
  reg                       tmr_load;
  reg [CW-1:0]              tmr_value;
  reg                       tmr_tick;
  reg [`TKSU_SEL_W-1:0]     sel_code;
  wire                      tmr_done;
  wire                      wr_en;
  wire                      setup;
  wire                      start_req;
  wire                      start_ok;
  wire                      busy;
  wire                      eoc_set;
  wire                      drop_set;
  wire [`TKSU_ST_W-1:0]     st_set;
  wire [`TKSU_ST_W-1:0]     st_clr;
  integer                   i;

  assign setup    = psel & ~penable;
  assign wr_en    = psel & penable & pready_ff & pwrite & ~pslverr_ff;
  assign busy     = (state_ff != ST_IDLE);
  assign start_req = wr_en && paddr == `TKSU_OFF_START_DATA;
  // measurement only starts with the ADC powered and touch enabled
  assign start_ok = start_req & ~busy & adc_power_on_ff
                    & touch_enable_ff;
  assign eoc_set  = (state_ff == ST_CONV) & adc_conv_done;
  assign drop_set = start_req & ~start_ok;

  assign st_set = {drop_set, eoc_set};
  assign st_clr = (wr_en && paddr == `TKSU_OFF_STATUS) ?
                  pwdata[`TKSU_ST_W-1:0] : {`TKSU_ST_W{1'b0}};

  // ADC clock as a tick derived from the system clock
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      div_ff      <= {CW{1'b0}};
      adc_tick_ff <= 1'b0;
    end
    else if (div_ff >= ADC_DIV[CW-1:0] - {{(CW-1){1'b0}}, 1'b1})
    begin
      div_ff      <= {CW{1'b0}};
      adc_tick_ff <= 1'b1;
    end
    else
    begin
      div_ff      <= div_ff + {{(CW-1){1'b0}}, 1'b1};
      adc_tick_ff <= 1'b0;
    end
  end

  // selector of the requested channel; channels beyond nine use code 0
  always @*
  begin
    sel_code = {`TKSU_SEL_W{1'b0}};
    for (i = 0; i < `TKSU_SEL_NUM; i = i + 1)
      if (adc_channel_ff == i[`TKSU_SEQ_CH_W-1:0])
        sel_code = adc_sample_time_second_ff[i*3 +: 3];
  end

  // sequencer
  always @*
  begin
    nxt_state = state_ff;
    tmr_load  = 1'b0;
    tmr_value = {CW{1'b0}};
    tmr_tick  = 1'b0;
    case (state_ff)
      ST_IDLE:
      begin
        if (start_ok)
        begin
          nxt_state = ST_DISCH;
          tmr_load  = 1'b1;
          tmr_value = {1'b0, pwdata[`TKSU_DCG_W-1:0]};
        end
      end
      ST_DISCH:
      begin
        tmr_tick = adc_tick_ff;
        if (tmr_done)
        begin
          nxt_state = ST_CHGSEL;
          tmr_load  = 1'b1;
          tmr_value = tksu_chg_cycles(sel_code);
        end
      end
      ST_CHGSEL:
      begin
        tmr_tick = adc_tick_ff;
        if (tmr_done)
        begin
          nxt_state = ST_CHGOFF;
          tmr_load  = 1'b1;
          tmr_value = {1'b0, chg_offset_ff};
        end
      end
      ST_CHGOFF:
      begin
        tmr_tick = 1'b1;
        if (tmr_done)
          nxt_state = ST_CONV;
      end
      ST_CONV:
      begin
        if (adc_conv_done)
          nxt_state = ST_IDLE;
      end
      default:
        nxt_state = ST_IDLE;
    endcase
  end

  tksu_phase_timer #(
    .CNT_W      (CW)
  ) u_timer (
    .pclk       (pclk),
    .presetn    (presetn),
    .load       (tmr_load),
    .load_value (tmr_value),
    .tick       (tmr_tick),
    .done_ff    (tmr_done)
  );

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_ff          <= ST_IDLE;
      discharge_en_ff   <= 1'b0;
      charge_en_ff      <= 1'b0;
      adc_conv_start_ff <= 1'b0;
      result_ff         <= `TKSU_RST_DATA;
    end
    else
    begin
      state_ff          <= nxt_state;
      discharge_en_ff   <= (nxt_state == ST_DISCH);
      charge_en_ff      <= (nxt_state == ST_CHGSEL) ||
                           (nxt_state == ST_CHGOFF);
      adc_conv_start_ff <= (state_ff == ST_CHGOFF) &&
                           (nxt_state == ST_CONV);
      if (eoc_set)
        result_ff <= adc_conv_data;
    end
  end

  // software registers
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      adc_power_on_ff           <= 1'b0;
      touch_enable_ff           <= 1'b0;
      adc_channel_ff            <= `TKSU_RST_SEQ;
      mask_ff                   <= `TKSU_RST_MASK;
      adc_sample_time_second_ff <= `TKSU_RST_CHARGE2;
      chg_offset_ff             <= `TKSU_RST_OFFSET;
      dcg_time_ff               <= `TKSU_RST_DCG;
    end
    else if (wr_en)
    begin
      case (paddr)
        `TKSU_OFF_CTRL:
        begin
          adc_power_on_ff <= pwdata[`TKSU_CTRL_POWER_BIT];
          touch_enable_ff <= pwdata[`TKSU_CTRL_TOUCH_BIT];
        end
        `TKSU_OFF_SEQ:
          adc_channel_ff <= pwdata[`TKSU_SEQ_CH_W-1:0];
        `TKSU_OFF_MASK:
          mask_ff <= pwdata[`TKSU_ST_W-1:0];
        `TKSU_OFF_CHARGE2:
          adc_sample_time_second_ff <=
            pwdata[`TKSU_CHARGE2_W-1:0];
        `TKSU_OFF_CHGOFFSET:
          chg_offset_ff <= pwdata[`TKSU_OFFSET_W-1:0];
        `TKSU_OFF_START_DATA:
        begin
          if (start_ok)
            dcg_time_ff <= pwdata[`TKSU_DCG_W-1:0];
        end
        default:
          dcg_time_ff <= dcg_time_ff;
      endcase
    end
  end

  // sticky status: a set in the clearing cycle wins
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      status_ff <= {`TKSU_ST_W{1'b0}};
      irq_ff    <= 1'b0;
    end
    else
    begin
      status_ff <= (status_ff & ~st_clr) | st_set;
      irq_ff    <= |(((status_ff & ~st_clr) | st_set) & mask_ff);
    end
  end

  // read mux and decode
  always @*
  begin
    nxt_rdata = 32'h00000000;
    nxt_err   = 1'b0;
    case (paddr)
      `TKSU_OFF_CTRL:
      begin
        nxt_rdata[`TKSU_CTRL_POWER_BIT] = adc_power_on_ff;
        nxt_rdata[`TKSU_CTRL_TOUCH_BIT] = touch_enable_ff;
      end
      `TKSU_OFF_SEQ:
        nxt_rdata[`TKSU_SEQ_CH_W-1:0] = adc_channel_ff;
      `TKSU_OFF_STATUS:
      begin
        nxt_rdata[`TKSU_ST_W-1:0]     = status_ff;
        nxt_rdata[`TKSU_ST_BUSY_BIT]  = busy;
      end
      `TKSU_OFF_MASK:
        nxt_rdata[`TKSU_ST_W-1:0] = mask_ff;
      `TKSU_OFF_CHARGE2:
        nxt_rdata[`TKSU_CHARGE2_W-1:0] =
          adc_sample_time_second_ff;
      `TKSU_OFF_CHGOFFSET:
        nxt_rdata[`TKSU_DATA_W-1:0] = adc_injected_result_first;
      `TKSU_OFF_START_DATA:
        nxt_rdata[`TKSU_DATA_W-1:0] = result_ff;
      default:
        nxt_err = 1'b1;
    endcase
  end

  // zero-wait apb: answer prepared in setup, ready in the access cycle
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_ff  <= 32'h00000000;
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end
    else
    begin
      pready_ff  <= setup;
      pslverr_ff <= setup & nxt_err;
      if (setup && !pwrite)
        prdata_ff <= nxt_rdata;
    end
  end

endmodule // tksu_charge_ctrl

// ==== testbench/tksu_charge_ctrl_assertions.sv ====
// port-level assertions of the touch charge controller
`timescale 1ns/1ps
module tksu_charge_ctrl_chk (
  // clock and reset
  input wire        pclk,
  input wire        presetn,
  // apb
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata_ff,
  // adc and electrodes
  input wire [15:0] adc_injected_result_first,
  input wire        adc_power_on_ff,
  input wire        touch_enable_ff,
  input wire [4:0]  adc_channel_ff,
  input wire [29:0] adc_sample_time_second_ff,
  input wire        adc_conv_start_ff,
  input wire        discharge_en_ff,
  input wire        charge_en_ff
);
  wire wacc   = psel && penable && pwrite;
  wire wstart = wacc && paddr == 8'h4C;
  wire rsetup = psel && !penable && !pwrite;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_conv_pulse;
    adc_conv_start_ff ##1 !adc_conv_start_ff;
  endsequence
  sel_store_a: assert property (wacc && paddr == 8'h10 |=>
    adc_sample_time_second_ff == $past(pwdata[29:0]))
    else $error("selector word not stored");
  ctrl_bits_a: assert property (wacc && paddr == 8'h00 |=>
    {touch_enable_ff, adc_power_on_ff} == $past(pwdata[1:0]))
    else $error("control bits not stored");
  chan_slot_a: assert property (wacc && paddr == 8'h04 |=>
    adc_channel_ff == $past(pwdata[4:0]))
    else $error("channel slot not stored");
  inj_read_a: assert property (rsetup && paddr == 8'h3C |=>
    prdata_ff == {16'h0000, $past(adc_injected_result_first)})
    else $error("offset address read wrong");
  start_cause_a: assert property ($rose(discharge_en_ff) |->
    $past(wstart)) else $error("discharge without start write");
  start_refused_a: assert property (wstart && !touch_enable_ff
    && !discharge_en_ff |=> !discharge_en_ff)
    else $error("start taken with touch off");
  phase_excl_a: assert property (!(discharge_en_ff && charge_en_ff))
    else $error("discharge and charge together");
  dcg_to_chg_a: assert property ($fell(discharge_en_ff) |->
    ##[0:2] charge_en_ff) else $error("charge does not follow");
  chg_to_conv_a: assert property ($fell(charge_en_ff) |->
    ##[0:2] s_conv_pulse) else $error("conversion does not follow");
endmodule // tksu_charge_ctrl_chk

bind tksu_charge_ctrl tksu_charge_ctrl_chk tksu_charge_ctrl_chk_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_ff(prdata_ff),
  .adc_injected_result_first(adc_injected_result_first),
  .adc_power_on_ff(adc_power_on_ff), .touch_enable_ff(touch_enable_ff),
  .adc_channel_ff(adc_channel_ff),
  .adc_sample_time_second_ff(adc_sample_time_second_ff),
  .adc_conv_start_ff(adc_conv_start_ff),
  .discharge_en_ff(discharge_en_ff), .charge_en_ff(charge_en_ff)
);

// ==== testbench/tksu_adc_model.sv ====
// adc stand-in: answers a conversion start after a chosen delay
`timescale 1ns/1ps
module tksu_adc_model (
  // clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // request and answer
  input  wire        conv_start,
  input  wire [7:0]  lat,
  input  wire [15:0] value,
  output reg         done_ff,
  output reg  [15:0] data_ff
);
  reg [7:0] cnt_ff;
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_ff  <= 8'h00;
      done_ff <= 1'b0;
      data_ff <= 16'h0000;
    end
    else
    begin
      done_ff <= 1'b0;
      // data is only valid with done
      data_ff <= ~data_ff;
      if (conv_start)
        cnt_ff <= lat;
      else if (cnt_ff != 8'h00)
        cnt_ff <= cnt_ff - 8'h01;
      if (cnt_ff == 8'h01)
      begin
        done_ff <= 1'b1;
        data_ff <= value;
      end
    end
  end
endmodule // tksu_adc_model

// ==== testbench/touch_key_charge_control_bench.sv ====
// self-checking bench of the touch charge controller
`timescale 1ns/1ps
module touch_key_charge_control_bench;
  reg         pclk, presetn, psel, penable, pwrite, e, m;
  reg  [7:0]  paddr, lat;
  reg  [31:0] pwdata, r, w;
  reg  [15:0] inj, val;
  wire [31:0] prdata_ff;
  wire [15:0] data;
  wire        pready_ff, pslverr_ff, done, start, dcg, chg, irq_ff;
  reg  [15:0] exp_q[$];
  integer     n_fail, checked, chg_n, dcg_n, chg0, dcg0;
  integer     code, ch, dc, off, xc;
  tksu_charge_ctrl #(.ADC_DIV(2)) tksu_charge_ctrl_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata_ff(prdata_ff), .pready_ff(pready_ff), .pslverr_ff(pslverr_ff),
    .adc_conv_done(done), .adc_conv_data(data),
    .adc_injected_result_first(inj), .adc_power_on_ff(),
    .touch_enable_ff(), .adc_channel_ff(), .adc_sample_time_second_ff(),
    .adc_conv_start_ff(start), .discharge_en_ff(dcg), .charge_en_ff(chg),
    .irq_ff(irq_ff));
  tksu_adc_model tksu_adc_model_i (.pclk(pclk), .presetn(presetn),
    .conv_start(start), .lat(lat), .value(val), .done_ff(done),
    .data_ff(data));
  initial
  begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  // phase counters that count cycles with chg or dcg high and are never cleared; each measurement takes differences
  always @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      chg_n <= 0;
      dcg_n <= 0;
    end
    else
    begin
      if (chg)
        chg_n <= chg_n + 1;
      if (dcg)
        dcg_n <= dcg_n + 1;
    end
  task check(input [31:0] seen, input [31:0] exp);
  begin
    checked = checked + 1;
    if (seen !== exp)
    begin
      n_fail = n_fail + 1;
      $display("mismatch at %0t: got %h want %h", $time, seen, exp);
    end
  end
  endtask
  task apb(input wr, input [7:0] a, input [31:0] d);
  begin
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // pready_ff ends this wait; the watchdog ends it only if pready_ff never rises
    while (pready_ff !== 1'b1)
      @(posedge pclk);
    r = prdata_ff;
    e = pslverr_ff;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  end
  endtask
  task rd(input [7:0] a, input [31:0] x);
  begin
    apb(1'b0, a, 32'h00000000);
    check(r, x);
  end
  endtask
  task finish_test;
  begin
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  end
  endtask
  initial
  begin
    #(25 * 40000);
    n_fail = n_fail + 1;
    finish_test;
  end
  initial
  begin
    {psel, penable, pwrite, presetn, paddr, pwdata} = 0;
    {n_fail, checked} = 0;
    lat = 8'h01;
    val = 16'h0000;
    w = $urandom(29);
    inj = 16'($urandom);
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(8'h10, 32'h00000000);
    rd(8'h4C, 32'h00000000);
    rd(8'h3C, {16'h0000, inj});
    apb(1'b0, 8'h20, 32'h00000000);
    check(e, 1);
    repeat (4)
    begin
      w = $urandom;
      apb(1'b1, 8'h10, w);
      rd(8'h10, w & 32'h3FFFFFFF);
    end
    apb(1'b1, 8'h3C, 32'hFFFFFFFF);
    rd(8'h3C, {16'h0000, inj});
    apb(1'b1, 8'h4C, 32'h00000010);
    rd(8'h08, 32'h00000002);
    apb(1'b1, 8'h08, 32'h00000003);
    $display("test registers done");
    apb(1'b1, 8'h00, 32'h00000003);
    for (code = 0; code < 8; code = code + 1)
    begin
      ch = code + 2;
      dc = 1 + $urandom % 8;
      off = $urandom % 16;
      m = code % 2;
      lat <= 8'(1 + $urandom % 6);
      val <= 16'($urandom);
      apb(1'b1, 8'h04, ch);
      apb(1'b1, 8'h10, code << (3 * ch));
      apb(1'b1, 8'h3C, off);
      apb(1'b1, 8'h0C, {31'h0, m});
      exp_q.push_back(val);
      chg0 = chg_n;
      dcg0 = dcg_n;
      apb(1'b1, 8'h4C, dc);
      while (done !== 1'b1)
        @(posedge pclk);
      repeat (3) @(posedge pclk);
      xc = (4 + code[2] + 2 * code[1:0]) * 2 + off;
      chg0 = chg_n - chg0;
      dcg0 = dcg_n - dcg0;
      check(chg0 >= xc - 1 && chg0 <= xc + 4, 1);
      check(dcg0 >= 2 * dc && dcg0 <= 2 * dc + 3, 1);
      check(irq_ff, m);
      rd(8'h08, 32'h00000001);
      rd(8'h4C, {16'h0000, exp_q.pop_front()});
      apb(1'b1, 8'h08, 32'h00000001);
      @(posedge pclk);
      check(irq_ff, 0);
    end
    $display("test measurements done");
    finish_test;
  end
endmodule // touch_key_charge_control_bench
